//--- design/fault_log_recorder.sv
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module fault_log_recorder #(
  parameter int unsigned TICK_CYCLES = fault_log_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // AXI4-Lite slave
  input  wire logic [4:0]   awaddr,
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  input  wire logic         wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  wire logic         bready,
  input  wire logic [4:0]   araddr,
  input  wire logic         arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  wire logic         rready,
  // Telemetry pass results
  input  wire logic         pass_done,
  input  wire logic [159:0] pass_record,
  input  wire logic [15:0]  vout0,
  input  wire logic [15:0]  vout1,
  input  wire logic [15:0]  iin0,
  input  wire logic [15:0]  iin1,
  input  wire logic [15:0]  vin,
  input  wire logic [15:0]  ext_temp0,
  input  wire logic [15:0]  ext_temp1,
  input  wire logic [15:0]  die_temp_reading,
  input  wire logic [7:0]   die_temp_c,
  // Fault and peak control
  input  wire logic         fault_pulse,
  input  wire logic [7:0]   fault_source,
  input  wire logic         peak_reset_command,
  // Operating settings and their nonvolatile copies
  input  wire logic [255:0] op_settings,
  input  wire logic [255:0] nv_settings
);
  import fault_log_pkg::*;

  // Signed value of a 5-bit exponent, 11-bit mantissa word, scaled by 2^16
  function automatic logic signed [47:0] lin11_scaled(input logic [15:0] v);
    logic signed [47:0] m;
    logic [4:0]         sh;
    m  = {{37{v[10]}}, v[10:0]};
    sh = {~v[15], v[14:11]};
    return m <<< sh;
  endfunction

  // Bus state
  logic        awready_q, awready_d, wready_q, wready_d;
  logic [4:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // Control state
  logic [15:0] cfg_q, cfg_d;           // Global configuration word
  logic [7:0]  vstat_q, vstat_d;       // Vendor status byte
  logic        cml_q, cml_d;           // Communication/memory fault
  logic        rd_active_q, rd_active_d;
  logic [7:0]  rd_idx_q, rd_idx_d;     // Next block byte, 0 is length
  logic [12:0] tick_q, tick_d;
  logic [47:0] ts_q, ts_d, ts_cap_q, ts_cap_d;
  logic [7:0]  src_q, src_d;
  logic [15:0] vpk0_q, vpk0_d, vpk1_q, vpk1_d, ipk0_q, ipk0_d;
  logic [15:0] ipk1_q, ipk1_d, vinpk_q, vinpk_d;
  logic        ram_valid_q, ram_valid_d; // Log captured since reset or erase
  cap_state_type state_q, state_d;
  // Memories: rolling events, captured image, nonvolatile image
  logic [159:0] ring_q [EV_NUM];
  logic [159:0] cap_ev_q [EV_NUM];
  logic [159:0] nv_ev_q [NV_EV_NUM];
  logic [215:0] cap_hdr_q, nv_hdr_q, hdr_now;
  logic         nv_valid_q;            // Nonvolatile, never reset
  // Decoded events
  logic do_write, ar_take, wr_cmd, force_go, erase_go, compare_go, read_go;
  logic rd_pop, log_exists, trigger;
  logic [7:0] cmd, img_byte, b, rel;
  logic [2:0] ev;

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  // Command decode
  assign do_write   = !awready_q && !wready_q && !bvalid_q;
  assign ar_take    = arvalid && arready_q;
  assign cmd        = wdata_q[7:0];
  assign wr_cmd     = do_write && wstrb_q[0] && (awaddr_q == ADDR_CMD);
  assign read_go    = wr_cmd && (cmd == CMD_LOG_READ);
  assign force_go   = wr_cmd && (cmd == CMD_FORCE);
  assign erase_go   = wr_cmd && (cmd == CMD_ERASE);
  assign compare_go = wr_cmd && (cmd == CMD_COMPARE);
  assign rd_pop     = ar_take && (araddr == ADDR_DATA) && rd_active_q;
  assign log_exists = ram_valid_q || nv_valid_q;
  // Locked region ignores further faults and forced stores
  assign trigger = ((fault_pulse && cfg_q[CFG_LOG_EN]) || force_go) &&
                   (state_q == CAP_IDLE) && !log_exists && !erase_go;

  // Header image, byte 0 in the low bits
  assign hdr_now = {die_temp_reading[7:0], die_temp_reading[15:8],
                    ext_temp1[7:0], ext_temp1[15:8], ext_temp0[7:0], ext_temp0[15:8],
                    vinpk_q[7:0], vinpk_q[15:8], ipk1_q[7:0], ipk1_q[15:8],
                    ipk0_q[7:0], ipk0_q[15:8], vpk1_q[7:0], vpk1_q[15:8],
                    vpk0_q[7:0], vpk0_q[15:8], ts_cap_q, src_q,
                    ID_WORD[7:0], ID_WORD[15:8], PREFACE1, PREFACE0};

  // Byte of the log image at position rd_idx_q - 1
  always_comb begin
    b   = rd_idx_q - 8'h01;
    rel = b - HDR_BYTES;
    ev  = 3'(rel / EV_BYTES);
    if (!ram_valid_q && ev > 3'(NV_EV_NUM - 1)) begin
      ev = 3'(NV_EV_NUM - 1);
    end
    if (b < HDR_BYTES) begin
      img_byte = ram_valid_q ? cap_hdr_q[b*8 +: 8] : nv_hdr_q[b*8 +: 8];
    end else if (ram_valid_q) begin
      img_byte = cap_ev_q[ev][(rel % EV_BYTES)*8 +: 8];
    end else begin
      img_byte = nv_ev_q[ev[1:0]][(rel % EV_BYTES)*8 +: 8];
    end
  end

  // Next state of bus and control registers
  always_comb begin
    awready_d = awready_q;
    wready_d  = wready_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    cfg_d     = cfg_q;
    vstat_d   = vstat_q;
    cml_d     = cml_q;
    rd_active_d = rd_active_q;
    rd_idx_d  = rd_idx_q;
    tick_d    = tick_q + 13'h0001;
    ts_d      = ts_q;
    ts_cap_d  = ts_cap_q;
    src_d     = src_q;
    vpk0_d    = vpk0_q;
    vpk1_d    = vpk1_q;
    ipk0_d    = ipk0_q;
    ipk1_d    = ipk1_q;
    vinpk_d   = vinpk_q;
    ram_valid_d = ram_valid_q;
    state_d   = state_q;
    // Timestamp counter in 200 us steps
    if (tick_q == 13'(TICK_CYCLES - 1)) begin
      tick_d = 13'h0000;
      ts_d   = ts_q + 48'h000000000001;
    end
    // Address and data are taken independently
    if (awvalid && awready_q) begin
      awready_d = 1'b0;
      awaddr_d  = awaddr;
    end
    if (wvalid && wready_q) begin
      wready_d = 1'b0;
      wdata_d  = wdata;
      wstrb_d  = wstrb;
    end
    // Write response once both halves are held
    if (do_write) begin
      awready_d = 1'b1;
      wready_d  = 1'b1;
      bvalid_d  = 1'b1;
      bresp_d   = 2'h0;
      unique case (awaddr_q)
        ADDR_CMD: ;
        ADDR_STATUS: begin
          // Write one to clear
          if (wstrb_q[0] && wdata_q[VSTAT_FORCED]) vstat_d[VSTAT_FORCED] = 1'b0;
          if (wstrb_q[1] && wdata_q[ST_CML]) cml_d = 1'b0;
        end
        ADDR_CONFIG: begin
          if (wstrb_q[0]) cfg_d[7:0] = wdata_q[7:0];
          if (wstrb_q[1]) cfg_d[15:8] = wdata_q[15:8];
        end
        ADDR_DATA: ;
        default: bresp_d = 2'h2;
      endcase
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    // Read answer one cycle after the address is taken
    if (ar_take) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = 2'h0;
      unique case (araddr)
        ADDR_CMD:    rdata_d = 32'h00000000;
        ADDR_STATUS: rdata_d = {20'h00000, state_q != CAP_IDLE, nv_valid_q,
                                log_exists, cml_q, vstat_q};
        ADDR_CONFIG: rdata_d = {16'h0000, cfg_q};
        ADDR_DATA: begin
          if (!rd_active_q) begin
            rdata_d = 32'h00000000;
          end else if (rd_idx_q == 8'h00) begin
            rdata_d = {23'h000000, 1'b1, log_exists ? LOG_LEN : 8'h00};
          end else begin
            rdata_d = {23'h000000, 1'b1, img_byte};
          end
        end
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = 2'h2;
        end
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
    // Block read walks the image in ascending order
    if (rd_pop) begin
      rd_idx_d = rd_idx_q + 8'h01;
      if ((rd_idx_q == 8'h00 && !log_exists) || rd_idx_q == LOG_LEN) begin
        rd_active_d = 1'b0;
      end
    end
    if (read_go) begin
      rd_active_d = 1'b1;
      rd_idx_d    = 8'h00;
    end
    // Settings compare, set wins over clear
    if (compare_go && op_settings != nv_settings) cml_d = 1'b1;
    if (force_go && cfg_q[CFG_LOG_EN]) vstat_d[VSTAT_FORCED] = 1'b1;
    // Peaks track each completed pass
    if (peak_reset_command) begin
      vpk0_d  = 16'h0000;
      vpk1_d  = 16'h0000;
      ipk0_d  = 16'h0000;
      ipk1_d  = 16'h0000;
      vinpk_d = 16'h0000;
    end else if (pass_done) begin
      if (vout0 > vpk0_q) vpk0_d = vout0;
      if (vout1 > vpk1_q) vpk1_d = vout1;
      if (lin11_scaled(iin0) > lin11_scaled(ipk0_q)) ipk0_d = iin0;
      if (lin11_scaled(iin1) > lin11_scaled(ipk1_q)) ipk1_d = iin1;
      if (lin11_scaled(vin) > lin11_scaled(vinpk_q)) vinpk_d = vin;
    end
    // Capture sequence
    unique case (state_q)
      CAP_IDLE: begin
        if (trigger) begin
          ts_cap_d = ts_q;
          src_d    = fault_source;
          state_d  = CAP_WAIT;
        end
      end
      CAP_WAIT:  if (pass_done) state_d = CAP_SNAP;
      CAP_SNAP: begin
        ram_valid_d = 1'b1;
        state_d = (die_temp_c > TEMP_HOT) ? CAP_HOT : CAP_WRITE;
      end
      CAP_HOT:   if (die_temp_c < TEMP_COOL) state_d = CAP_WRITE;
      CAP_WRITE: state_d = CAP_IDLE;
    endcase
    if (erase_go) begin
      ram_valid_d = 1'b0;
      state_d     = CAP_IDLE;
    end
  end

  // Register all control state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      awaddr_q  <= 5'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= 2'h0;
      cfg_q     <= CFG_RESET;
      vstat_q   <= 8'h00;
      cml_q     <= 1'b0;
      rd_active_q <= 1'b0;
      rd_idx_q  <= 8'h00;
      tick_q    <= 13'h0000;
      ts_q      <= 48'h000000000000;
      ts_cap_q  <= 48'h000000000000;
      src_q     <= 8'h00;
      vpk0_q    <= 16'h0000;
      vpk1_q    <= 16'h0000;
      ipk0_q    <= 16'h0000;
      ipk1_q    <= 16'h0000;
      vinpk_q   <= 16'h0000;
      ram_valid_q <= 1'b0;
      state_q   <= CAP_IDLE;
    end else begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      cfg_q     <= cfg_d;
      vstat_q   <= vstat_d;
      cml_q     <= cml_d;
      rd_active_q <= rd_active_d;
      rd_idx_q  <= rd_idx_d;
      tick_q    <= tick_d;
      ts_q      <= ts_d;
      ts_cap_q  <= ts_cap_d;
      src_q     <= src_d;
      vpk0_q    <= vpk0_d;
      vpk1_q    <= vpk1_d;
      ipk0_q    <= ipk0_d;
      ipk1_q    <= ipk1_d;
      vinpk_q   <= vinpk_d;
      ram_valid_q <= ram_valid_d;
      state_q   <= state_d;
    end
  end

  // Event memories: rolling buffer, captured image, nonvolatile copy
  for (genvar i = 0; i < EV_NUM; i++) begin : g_ev
    always_ff @(posedge aclk) begin
      if (pass_done) begin
        ring_q[i] <= (i == 0) ? pass_record : ring_q[(i == 0) ? 0 : i - 1];
      end
      if (state_q == CAP_SNAP) cap_ev_q[i] <= ring_q[i];
      if (i < NV_EV_NUM && state_q == CAP_WRITE) begin
        nv_ev_q[(i < NV_EV_NUM) ? i : 0] <= cap_ev_q[i];
      end
    end
  end

  // Header images and nonvolatile valid flag
  always_ff @(posedge aclk) begin
    if (state_q == CAP_SNAP) cap_hdr_q <= hdr_now;
    if (state_q == CAP_WRITE) begin
      nv_hdr_q   <= cap_hdr_q;
      nv_valid_q <= 1'b1;
    end
    if (erase_go) nv_valid_q <= 1'b0;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pass_in_wait;
    state_q == CAP_WAIT && pass_done && !erase_go;
  endsequence
  sequence s_snap_then_valid;
    state_q == CAP_SNAP ##1 ram_valid_q;
  endsequence

  a_len_zero: assert property (rd_pop && rd_idx_q == 8'h00 && !log_exists |=>
    rvalid_q && rdata_q == 32'h00000100 && !rd_active_q)
    else $error("empty log length not zero");
  a_len_full: assert property (rd_pop && rd_idx_q == 8'h00 && log_exists |=>
    rdata_q[7:0] == 8'h93 && rd_idx_q == 8'h01) else $error("log length not 147");
  a_erase_clears: assert property (erase_go |=> !nv_valid_q && !ram_valid_q)
    else $error("erase left a log");
  a_compare_flag: assert property (compare_go && op_settings != nv_settings |=> cml_q)
    else $error("compare mismatch not flagged");
  a_force_flag: assert property (force_go && cfg_q[7] |=> vstat_q[3])
    else $error("forced store flag not set");
  a_hot_hold: assert property (state_q == CAP_HOT && die_temp_c >= 8'h7D && !erase_go
    |=> state_q == CAP_HOT && $stable(nv_valid_q)) else $error("hot write not deferred");
  a_lock_hold: assert property (nv_valid_q && !erase_go |=> nv_valid_q && $stable(nv_hdr_q))
    else $error("locked log changed");
  a_pass_wait: assert property (s_pass_in_wait |=> s_snap_then_valid)
    else $error("capture did not follow pass");
  a_ts_latch: assert property (trigger |=> ts_cap_q == $past(ts_q) && state_q == CAP_WAIT)
    else $error("timestamp not latched");
  a_read_order: assert property (rd_pop && !read_go |=> rd_idx_q == $past(rd_idx_q) + 8'h01)
    else $error("block bytes out of order");
endmodule

//--- design/fault_log_pkg.sv
// Summary of operation
// - Compare command flags mismatch with settings
// - Codes EE read, EA store, EC erase
// - Rolling RAM buffer refreshed every pass
// - Fault copies buffer to nonvolatile, locks it
// - Read returns first log since erase
// - No log gives length zero
// - Log present gives 147 bytes
// - Erase wipes and unlocks log region
// - Nonvolatile read repeats fourth event twice
// - Forced store acts as fault, sets flag only with logging enabled
// - Hot die defers nonvolatile write until cool
// - Bytes 0-1 hold ASCII preface, bytes 2-3 ID word
// - Bytes 5-10 hold timestamp, LSB first
// - Bytes 11-20 hold peaks, high first
// - Bytes 21-26 hold temperatures, high first
// - Linear fields use PMBus encodings
// - Finish current pass before storing log
package fault_log_pkg;
  // Command codes
  localparam logic [7:0] CMD_LOG_READ = 8'hEE;
  localparam logic [7:0] CMD_FORCE    = 8'hEA;
  localparam logic [7:0] CMD_ERASE    = 8'hEC;
  localparam logic [7:0] CMD_COMPARE  = 8'hF0;
  // Register byte offsets
  localparam int unsigned ADDR_W      = 5;
  localparam logic [4:0]  ADDR_CMD    = 5'h00;
  localparam logic [4:0]  ADDR_STATUS = 5'h04;
  localparam logic [4:0]  ADDR_CONFIG = 5'h08;
  localparam logic [4:0]  ADDR_DATA   = 5'h0C;
  // Field positions and reset values
  localparam int unsigned CFG_LOG_EN   = 7;
  localparam int unsigned VSTAT_FORCED = 3;
  localparam int unsigned ST_CML       = 8;
  localparam logic [15:0] CFG_RESET    = 16'h0080;
  // Log image layout
  localparam logic [7:0]  LOG_LEN   = 8'h93;
  localparam logic [7:0]  HDR_BYTES = 8'h1B;
  localparam logic [7:0]  EV_BYTES  = 8'h14;
  localparam int unsigned EV_NUM    = 6;
  localparam int unsigned NV_EV_NUM = 4;
  localparam logic [7:0]  PREFACE0  = 8'h41; // Arbitrary value
  localparam logic [7:0]  PREFACE1  = 8'h42; // Arbitrary value
  localparam logic [15:0] ID_WORD   = 16'h0000; // Arbitrary value
  // Die temperature thresholds in degrees C
  localparam logic [7:0] TEMP_HOT  = 8'h82;
  localparam logic [7:0] TEMP_COOL = 8'h7D;
  // Timestamp step
  localparam int unsigned TICK_NS   = 200000;
  localparam int unsigned CLK_NS    = 40;
  localparam int unsigned TICK_CYC  = TICK_NS / CLK_NS;
  // Capture sequence
  typedef enum logic [2:0] {CAP_IDLE, CAP_WAIT, CAP_SNAP, CAP_HOT, CAP_WRITE} cap_state_type;
endpackage

//--- verif/log_host_model.sv
`timescale 1ns/1ps
// Register bus host: holds each request until its ready is seen
module log_host_model (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic [4:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // Read channels
  output logic [4:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // Idle bus from time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = 0;
    {araddr, arvalid, rready} = 0;
  end

  // One write; address and data offered together
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // No cycle limit of its own; slow answers are waited for
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  // One read; data taken at the edge where rvalid is seen
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

//--- verif/fault_log_recorder_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the fault log recorder
module fault_log_recorder_tb;
  import fault_log_pkg::*;
  localparam int TK = 4;  // Shortened timestamp step
  // Clock, reset and bus
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [4:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  // Telemetry, fault and settings inputs
  logic pass_done, fault_pulse, peak_reset_command;
  logic [159:0] pass_record;
  logic [15:0] vout0, vout1, iin0, iin1, vin, ext_temp0, ext_temp1, die_temp_reading;
  logic [7:0] die_temp_c, fault_source;
  logic [255:0] op_settings, nv_settings;
  // Bench state and expectations
  int errors = 0, num_checks = 0, cyc = 0, rst_cyc = 0, ts_exp, ts_first;
  logic [159:0] hist[$], hcap[$];
  logic [15:0] pk[5], pk_cap[5], tv[3], t_cap[3];
  logic [7:0] blk[147];
  logic [31:0] rv;
  logic [1:0] rs;

  always #20 aclk = ~aclk;

  log_host_model i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  fault_log_recorder #(.TICK_CYCLES(TK)) i_fault_log_recorder (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pass_done(pass_done), .pass_record(pass_record), .vout0(vout0), .vout1(vout1),
    .iin0(iin0), .iin1(iin1), .vin(vin), .ext_temp0(ext_temp0), .ext_temp1(ext_temp1),
    .die_temp_reading(die_temp_reading), .die_temp_c(die_temp_c),
    .fault_pulse(fault_pulse), .fault_source(fault_source),
    .peak_reset_command(peak_reset_command), .op_settings(op_settings),
    .nv_settings(nv_settings));

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Cycle count and hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      finish_test();
    end
  end

  // Compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Held reset of three cycles
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rst_cyc = cyc;
    // Peaks restart from zero after reset
    pk = '{default: 16'h0};
  endtask

  // One telemetry pass with random readings; peaks tracked here
  task automatic pass();
    logic [15:0] v[5];
    logic [159:0] rec;
    @(posedge aclk);
    rec = {$urandom, $urandom, $urandom, $urandom, $urandom};
    for (int i = 0; i < 5; i++) begin
      v[i] = (i < 2) ? 16'($urandom) : {6'h00, 10'($urandom)};
      pk[i] = (v[i] > pk[i]) ? v[i] : pk[i];
    end
    for (int i = 0; i < 3; i++) tv[i] = 16'($urandom);
    {vout0, vout1, iin0, iin1, vin} <= {v[0], v[1], v[2], v[3], v[4]};
    {ext_temp0, ext_temp1, die_temp_reading} <= {tv[0], tv[1], tv[2]};
    pass_record <= rec;
    hist.push_front(rec);
    pass_done <= 1'b1;
    @(posedge aclk);
    pass_done <= 1'b0;
  endtask

  // Fault pulse; timestamp expectation taken at the trigger
  task automatic fault(input logic [7:0] fs);
    @(posedge aclk);
    fault_pulse <= 1'b1;
    fault_source <= fs;
    ts_exp = (cyc - rst_cyc) / TK;
    @(posedge aclk);
    fault_pulse <= 1'b0;
  endtask

  // Status poll with a bounded number of reads
  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin
      i_host.rd(ADDR_STATUS, rv, rs);
      n++;
    end while (rv[b] !== v && n < 40);
    chk(rv[b], v);
  endtask

  task automatic cmd(input logic [7:0] c);
    i_host.wr(ADDR_CMD, {24'h0, c}, rs);
  endtask

  // Block read: length first, then bytes in ascending order
  task automatic get_block(input logic [7:0] len);
    cmd(CMD_LOG_READ);
    i_host.rd(ADDR_DATA, rv, rs);
    chk(rv[7:0], len);
    for (int k = 0; k < len; k++) begin
      i_host.rd(ADDR_DATA, rv, rs);
      blk[k] = rv[7:0];
    end
  endtask

  // Whole log image against the captured expectation
  task automatic chk_log(input logic [7:0] fs, input int nev);
    int ts;
    chk({blk[0], blk[1], blk[2], blk[3]}, {PREFACE0, PREFACE1, ID_WORD});
    chk(blk[4], fs);
    ts = {blk[6], blk[5]};
    chk({blk[10], blk[9], blk[8], blk[7]}, 32'h0);
    chk(ts >= ts_exp - 2 && ts <= ts_exp + 2, 1'b1);
    for (int i = 0; i < 5; i++) chk({blk[11+2*i], blk[12+2*i]}, pk_cap[i]);
    for (int i = 0; i < 3; i++) chk({blk[21+2*i], blk[22+2*i]}, t_cap[i]);
    for (int e = 0; e < 6; e++)
      for (int k = 0; k < 20; k++)
        chk(blk[27+20*e+k], hcap[(e < nev) ? e : nev - 1][8*k+:8]);
  endtask

  initial begin
    rv = $urandom(92);
    {pass_done, fault_pulse, peak_reset_command, pass_record, fault_source} = 0;
    {vout0, vout1, iin0, iin1, vin, ext_temp0, ext_temp1, die_temp_reading} = 0;
    die_temp_c = 8'h32;
    nv_settings = {8{$urandom}};
    op_settings = nv_settings;
    pk = '{default: 16'h0};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rst_cyc = cyc;
    // Reset value and unmapped places
    i_host.rd(ADDR_CONFIG, rv, rs);
    chk(rv, {16'h0, CFG_RESET});
    i_host.rd(5'h10, rv, rs);
    chk({rs, rv}, {2'h2, 32'h0});
    i_host.wr(5'h14, 32'h0, rs);
    chk(rs, 2'h2);
    // Erased region answers with an empty block
    cmd(CMD_ERASE);
    get_block(8'h00);
    // Peaks cleared, then six passes fill the buffer before the fault
    @(posedge aclk);
    peak_reset_command <= 1'b1;
    pk = '{default: 16'h0};
    @(posedge aclk);
    peak_reset_command <= 1'b0;
    for (int i = 0; i < 6; i++) pass();
    fault(8'h5A);
    i_host.rd(ADDR_STATUS, rv, rs);
    chk(rv[9], 1'b0);
    pass();
    pk_cap = pk;
    t_cap = tv;
    hcap = hist;
    wait_st(10, 1'b1);
    get_block(LOG_LEN);
    chk_log(8'h5A, 6);
    ts_first = ts_exp;
    // Locked region ignores a later fault
    fault(8'hA5);
    pass();
    pass();
    get_block(LOG_LEN);
    chk(blk[4], 8'h5A);
    // Retained image after reset repeats the fourth event
    do_reset();
    ts_exp = ts_first;
    get_block(LOG_LEN);
    chk_log(8'h5A, 4);
    // Erase unlocks and empties the region
    cmd(CMD_ERASE);
    get_block(8'h00);
    i_host.rd(ADDR_STATUS, rv, rs);
    chk(rv[10:9], 2'h0);
    // Forced store on a hot die stays in RAM until below the low limit
    die_temp_c <= 8'd131;
    cmd(CMD_FORCE);
    pass();
    wait_st(9, 1'b1);
    chk(rv[3], 1'b1);
    chk(rv[10], 1'b0);
    die_temp_c <= 8'd125;
    repeat (20) @(posedge aclk);
    i_host.rd(ADDR_STATUS, rv, rs);
    chk(rv[10], 1'b0);
    die_temp_c <= 8'd124;
    wait_st(10, 1'b1);
    get_block(LOG_LEN);
    i_host.wr(ADDR_STATUS, 32'h8, rs);
    wait_st(3, 1'b0);
    // Logging disabled: fault ignored, forced store kept without the flag
    i_host.wr(ADDR_CONFIG, 32'h0, rs);
    cmd(CMD_ERASE);
    fault(8'h11);
    pass();
    pass();
    i_host.rd(ADDR_STATUS, rv, rs);
    chk(rv[9], 1'b0);
    cmd(CMD_FORCE);
    pass();
    wait_st(10, 1'b1);
    chk(rv[3], 1'b0);
    // Settings compare: equal, then one random bit apart
    cmd(CMD_COMPARE);
    wait_st(8, 1'b0);
    op_settings <= nv_settings ^ (256'h1 << ($urandom % 256));
    cmd(CMD_COMPARE);
    wait_st(8, 1'b1);
    finish_test();
  end
endmodule
